// *** shared/bws_pkg.sv ***
/*
  Constants for the bridge window and downstream status register bank:
  byte offsets, field positions, read-only values and reset values.
  Assumes a 32-bit register bus with byte addresses.
*/
package bws_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CMD   = 8'h04;
  localparam logic [7:0] OFS_IOST  = 8'h1c;
  localparam logic [7:0] OFS_MEM   = 8'h20;
  localparam logic [7:0] OFS_IOUP  = 8'h30;

  // command register
  localparam int         CMD_PERR_EN_BIT = 6;
  localparam logic       CMD_PERR_EN_RST = 1'b0;

  // i/o window low half and upper-half reset
  localparam logic [3:0]  IO_ADDR_IND   = 4'h1;
  localparam logic [3:0]  IO_NIB_RST    = 4'h0;
  localparam logic [11:0] IO_LOW_START  = 12'h000;
  localparam logic [11:0] IO_LOW_END    = 12'hfff;
  localparam logic [15:0] IO_UP_RST     = 16'h0000;

  // memory window
  localparam logic [3:0]  MEM_RO_NIB    = 4'h0;
  localparam logic [11:0] MEM_FIELD_RST = 12'h000;
  localparam logic [19:0] MEM_LOW_START = 20'h00000;
  localparam logic [19:0] MEM_LOW_END   = 20'hfffff;

  // downstream status, positions within the upper half-word
  localparam int ST_66MHZ  = 5;
  localparam int ST_FBB    = 7;
  localparam int ST_MDPE   = 8;
  localparam int ST_DEVSEL = 9;
  localparam int ST_STA    = 11;
  localparam int ST_RTA    = 12;
  localparam int ST_RMA    = 13;
  localparam int ST_RSE    = 14;
  localparam int ST_DPE    = 15;

  localparam logic       ST_66MHZ_VAL  = 1'b1;
  localparam logic       ST_FBB_VAL    = 1'b0;
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  localparam logic [15:0] ST_W1C_MASK  = 16'hf900;
  localparam logic [15:0] ST_RST       = 16'h0000;

  // bus slave states
  typedef enum logic [1:0]
  {
    BWS_IDLE = 2'h1,
    BWS_ACK  = 2'h2
  } bws_slave_t;

endpackage

// *** shared/bws_win_if.sv ***
/*
  Window compare carrier between the register bank and a window matcher.
  Assumes both ends share the register bank clock.
*/
`timescale 1ns/100ps
interface bws_win_if #(parameter int W = 32);
  logic [W-1:0] winStart;
  logic [W-1:0] winEnd;
  logic [W-1:0] reqAddr;
  logic         hit;

  modport cfg   (output winStart, output winEnd, output reqAddr,
                 input hit);
  modport match (input winStart, input winEnd, input reqAddr,
                 output hit);
endinterface

// *** rtl/bws_window_match.sv ***
/*
  Address window matcher: hit when start <= address <= end.
  Assumes the assembled start and end addresses are supplied already.
*/
`timescale 1ns/100ps
module bws_window_match
  import bws_pkg::*;
#(
  parameter int W = 32
)
(
  // window and address
  bws_win_if.match win
);

  initial
  begin
    if (W < 16 || W > 64)
      $error("bws_window_match: width out of range");
  end

  logic winEnabled;

  // an inverted window disables forwarding altogether
  assign winEnabled = (win.winEnd >= win.winStart);
  assign win.hit    = winEnabled && (win.reqAddr >= win.winStart)
                      && (win.reqAddr <= win.winEnd);

endmodule

// *** rtl/bws_cfg_regs.sv ***
/*
  Bridge forwarding windows and downstream status register bank, reached
  over an Avalon-MM slave with one wait state. Also decides whether an
  i/o or memory address falls inside its forwarding window.
  Assumes event inputs are synchronous to clk; abort and parity-detect
  inputs are one-cycle pulses, the _n inputs are active-low levels.
*/
// Summary of operation
// - i/o base and limit low nibbles read 1, read-only
// - i/o base nibble gives start bits 15:12, low bits zero, resets 0
// - i/o limit nibble gives end bits 15:12, low bits all ones
// - i/o start and end bits 31:16 come from upper-half register
// - i/o addresses compared against assembled window to forward
// - status bit 21 read-only, reads one
// - status bit 23 read-only, reads zero
// - bit 24 set on downstream parity error while command bit 6 set
// - status bits 26:25 read-only, always 01 medium decode
// - bit 27 set when bridge as target signals target abort
// - bit 28 set when bridge master receives target abort
// - bit 29 set when bridge master receives master abort
// - bit 30 set when downstream system error input asserted
// - bit 31 set on any detected parity error, no enable
// - memory base low four bits read-only zero
// - memory base field gives start bits 31:20, low bits zero
// - memory start and limit decide memory forwarding
// - memory limit field gives end bits 31:20, low bits ones
// - upper-half i/o start and end at offset 30h, reset zero
`timescale 1ns/100ps
module bws_cfg_regs
  import bws_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input  logic              clk,
  input  logic              reset,
  // avalon-mm slave
  input  logic [ADDR_W-1:0] avs_address,
  input  logic              avs_read,
  input  logic              avs_write,
  input  logic [31:0]       avs_writedata,
  input  logic [3:0]        avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  // downstream bus events
  input  logic              downstream_parity_error_n,
  input  logic              downstream_system_error_n,
  input  logic              targetAbortSignaled,
  input  logic              targetAbortReceived,
  input  logic              masterAbortReceived,
  input  logic              parityErrorDetected,
  // forwarding decisions
  input  logic [31:0]       ioReqAddr,
  input  logic [31:0]       memReqAddr,
  output logic              ioForward,
  output logic              memForward
);

  initial
  begin
    if (ADDR_W < 8)
      $error("bws_cfg_regs: address too narrow for offset 30h");
  end

  bws_slave_t  state_r;
  bws_slave_t  state_nxt;
  logic        wrAccept;
  logic        rdCapture;
  logic [7:0]  regAddr;
  logic [31:0] rdData_nxt;
  logic [31:0] readdata_r;

  logic        perrEn_r;
  logic [3:0]  ioBaseNib_r;
  logic [3:0]  ioLimNib_r;
  logic [15:0] ioUpStart_r;
  logic [15:0] ioUpEnd_r;
  logic [11:0] memBase_r;
  logic [11:0] memLim_r;
  logic [15:0] statFlags_r;
  logic [15:0] statFlags_nxt;
  logic [15:0] statSet;
  logic [15:0] statClr;
  logic        ioForward_r;
  logic        memForward_r;

  bws_win_if #(.W(32)) ioWin ();
  bws_win_if #(.W(32)) memWin ();

  // merges one write byte into a held byte under its lane enable
  function automatic logic [7:0] laneMerge(input logic [7:0] held,
                                           input logic [7:0] wr,
                                           input logic       en);
    laneMerge = en ? wr : held;
  endfunction

  // full downstream status half-word as software sees it
  function automatic logic [15:0] statusView(input logic [15:0] flags);
    logic [15:0] v;
    v = flags & ST_W1C_MASK;
    v[ST_66MHZ] = ST_66MHZ_VAL;
    v[ST_FBB] = ST_FBB_VAL;
    v[ST_DEVSEL +: 2] = DEVSEL_MEDIUM;
    statusView = v;
  endfunction

  // bus slave: one wait state on every access, unmapped reads zero
  assign regAddr         = avs_address[7:0];
  assign avs_waitrequest = (avs_read || avs_write) && (state_r == BWS_IDLE);
  assign wrAccept        = avs_write && (state_r == BWS_ACK);
  assign rdCapture       = avs_read && (state_r == BWS_IDLE);
  assign avs_readdata    = readdata_r;

  always_comb
  begin
    state_nxt = BWS_IDLE;
    unique case (state_r)
      BWS_IDLE:
      begin
        if (avs_read || avs_write)
          state_nxt = BWS_ACK;
      end
      BWS_ACK:
      begin
        state_nxt = BWS_IDLE;
      end
      default:
      begin
        state_nxt = BWS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state_r <= BWS_IDLE;
    else
      state_r <= state_nxt;
  end

  always_comb
  begin
    rdData_nxt = 32'h00000000;
    unique case (regAddr)
      OFS_CMD:
      begin
        rdData_nxt[CMD_PERR_EN_BIT] = perrEn_r;
      end
      OFS_IOST:
      begin
        rdData_nxt = {statusView(statFlags_r), ioLimNib_r, IO_ADDR_IND,
                      ioBaseNib_r, IO_ADDR_IND};
      end
      OFS_MEM:
      begin
        rdData_nxt = {memLim_r, MEM_RO_NIB, memBase_r, MEM_RO_NIB};
      end
      OFS_IOUP:
      begin
        rdData_nxt = {ioUpEnd_r, ioUpStart_r};
      end
      default:
      begin
        rdData_nxt = 32'h00000000;
      end
    endcase
  end

  // read data captured on the wait cycle so it stands at the accept edge
  always_ff @(posedge clk)
  begin
    if (reset)
      readdata_r <= 32'h00000000;
    else if (rdCapture)
      readdata_r <= rdData_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      perrEn_r <= CMD_PERR_EN_RST;
    else if (wrAccept && regAddr == OFS_CMD && avs_byteenable[0])
      perrEn_r <= avs_writedata[CMD_PERR_EN_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ioBaseNib_r <= IO_NIB_RST;
      ioLimNib_r  <= IO_NIB_RST;
    end
    else if (wrAccept && regAddr == OFS_IOST)
    begin
      if (avs_byteenable[0])
        ioBaseNib_r <= avs_writedata[7:4];
      if (avs_byteenable[1])
        ioLimNib_r <= avs_writedata[15:12];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ioUpStart_r <= IO_UP_RST;
      ioUpEnd_r   <= IO_UP_RST;
    end
    else if (wrAccept && regAddr == OFS_IOUP)
    begin
      ioUpStart_r[7:0]  <= laneMerge(ioUpStart_r[7:0], avs_writedata[7:0],
                                     avs_byteenable[0]);
      ioUpStart_r[15:8] <= laneMerge(ioUpStart_r[15:8],
                                     avs_writedata[15:8],
                                     avs_byteenable[1]);
      ioUpEnd_r[7:0]    <= laneMerge(ioUpEnd_r[7:0], avs_writedata[23:16],
                                     avs_byteenable[2]);
      ioUpEnd_r[15:8]   <= laneMerge(ioUpEnd_r[15:8], avs_writedata[31:24],
                                     avs_byteenable[3]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      memBase_r <= MEM_FIELD_RST;
      memLim_r  <= MEM_FIELD_RST;
    end
    else if (wrAccept && regAddr == OFS_MEM)
    begin
      if (avs_byteenable[0])
        memBase_r[3:0] <= avs_writedata[7:4];
      if (avs_byteenable[1])
        memBase_r[11:4] <= avs_writedata[15:8];
      if (avs_byteenable[2])
        memLim_r[3:0] <= avs_writedata[23:20];
      if (avs_byteenable[3])
        memLim_r[11:4] <= avs_writedata[31:24];
    end
  end

  // status flags: hardware sets, software writes ones to clear
  always_comb
  begin
    statSet          = 16'h0000;
    statSet[ST_MDPE] = !downstream_parity_error_n && perrEn_r;
    statSet[ST_STA]  = targetAbortSignaled;
    statSet[ST_RTA]  = targetAbortReceived;
    statSet[ST_RMA]  = masterAbortReceived;
    statSet[ST_RSE]  = !downstream_system_error_n;
    statSet[ST_DPE]  = parityErrorDetected;
    statClr          = 16'h0000;
    if (wrAccept && regAddr == OFS_IOST)
    begin
      if (avs_byteenable[2])
        statClr[7:0] = avs_writedata[23:16];
      if (avs_byteenable[3])
        statClr[15:8] = avs_writedata[31:24];
    end
    // a set in the clearing cycle survives
    statFlags_nxt = ((statFlags_r & ~statClr) | statSet)
                    & ST_W1C_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      statFlags_r <= ST_RST;
    else
      statFlags_r <= statFlags_nxt;
  end

  // window assembly; the decision is registered, one cycle late
  assign ioWin.winStart  = {ioUpStart_r, ioBaseNib_r, IO_LOW_START};
  assign ioWin.winEnd    = {ioUpEnd_r, ioLimNib_r, IO_LOW_END};
  assign ioWin.reqAddr   = ioReqAddr;
  assign memWin.winStart = {memBase_r, MEM_LOW_START};
  assign memWin.winEnd   = {memLim_r, MEM_LOW_END};
  assign memWin.reqAddr  = memReqAddr;

  bws_window_match #(.W(32)) ioMatch
  (
    .win (ioWin.match)
  );

  bws_window_match #(.W(32)) memMatch
  (
    .win (memWin.match)
  );

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ioForward_r  <= 1'b0;
      memForward_r <= 1'b0;
    end
    else
    begin
      ioForward_r  <= ioWin.hit;
      memForward_r <= memWin.hit;
    end
  end

  assign ioForward  = ioForward_r;
  assign memForward = memForward_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_IO_IND:
  assert property ((rdCapture && regAddr == OFS_IOST) |=>
                   (avs_readdata[3:0] == IO_ADDR_IND &&
                    avs_readdata[11:8] == IO_ADDR_IND))
    else $error("i/o addressing indicator wrong");

  AST_IO_START:
  assert property ((ioReqAddr == {ioUpStart_r, ioBaseNib_r, 12'h000} &&
                    ioWin.winEnd >= ioWin.winStart) |=> ioForward)
    else $error("i/o window start not forwarded");

  AST_IO_END:
  assert property ((ioReqAddr == {ioUpEnd_r, ioLimNib_r, 12'hfff} &&
                    ioWin.winEnd >= ioWin.winStart) |=> ioForward)
    else $error("i/o window end not forwarded");

  AST_IO_OUTSIDE:
  assert property ((ioReqAddr < {ioUpStart_r, ioBaseNib_r, 12'h000})
                   |=> !ioForward)
    else $error("i/o address below window forwarded");

  AST_STATUS_RO:
  assert property ((rdCapture && regAddr == OFS_IOST) |=>
                   (avs_readdata[21] && !avs_readdata[23] &&
                    avs_readdata[26:25] == 2'h1 &&
                    avs_readdata[22:16] == 7'h20))
    else $error("read-only status bits wrong");

  AST_PERR_SET:
  assert property ((!downstream_parity_error_n && perrEn_r) |=>
                   statFlags_r[ST_MDPE])
    else $error("parity flag not set");

  AST_PERR_GATED:
  assert property ((!perrEn_r && !statFlags_r[ST_MDPE]) |=>
                   !statFlags_r[ST_MDPE])
    else $error("parity flag set without cause");

  AST_EVENTS_SET:
  assert property ((targetAbortSignaled || targetAbortReceived ||
                    masterAbortReceived || !downstream_system_error_n ||
                    parityErrorDetected) |=>
                   ((statFlags_r[15:11] & $past(statSet[15:11])) ==
                    $past(statSet[15:11])))
    else $error("event flag not set");

  AST_W1C_CLEAR:
  assert property ((wrAccept && regAddr == OFS_IOST &&
                    avs_byteenable[3] && avs_writedata[31] &&
                    !parityErrorDetected) |=> !statFlags_r[ST_DPE])
    else $error("write one did not clear");

  AST_SET_WINS:
  assert property ((wrAccept && regAddr == OFS_IOST &&
                    avs_byteenable[3] && avs_writedata[31] &&
                    parityErrorDetected) |=> statFlags_r[ST_DPE])
    else $error("clear beat a coincident set");

  AST_MEM_RO:
  assert property ((rdCapture && regAddr == OFS_MEM) |=>
                   (avs_readdata[3:0] == 4'h0 &&
                    avs_readdata[19:16] == 4'h0))
    else $error("memory read-only nibble nonzero");

  AST_MEM_WIN:
  assert property (((memReqAddr == {memBase_r, 20'h00000} ||
                     memReqAddr == {memLim_r, 20'hfffff}) &&
                    memLim_r >= memBase_r) |=> memForward)
    else $error("memory window edge not forwarded");

  AST_INVERTED:
  assert property ((memLim_r < memBase_r) |=> !memForward)
    else $error("inverted memory window forwarded");

  AST_IOUP_WRITE:
  assert property ((wrAccept && regAddr == OFS_IOUP &&
                    avs_byteenable == 4'hf) |=>
                   ({ioUpEnd_r, ioUpStart_r} == $past(avs_writedata)))
    else $error("upper i/o register write lost");

  AST_WAIT_ONE:
  assert property ((avs_read && avs_waitrequest) |=> !avs_waitrequest)
    else $error("slave did not answer after one wait state");

  COV_IO_FWD: cover property (ioForward);
  COV_MEM_FWD: cover property (memForward);
  COV_W1C: cover property (wrAccept && regAddr == OFS_IOST &&
                           |statClr);
  COV_SET_CLR: cover property (|(statSet & statClr));

endmodule

// *** sim/bws_downstream_model.sv ***
/*
  Downstream bus agent model: raises one bridge event input on command.
  Assumes the register bank clock; a rise of go starts one event of len
  cycles. The _n lines are driven high while no event of theirs is active.
*/
`timescale 1ns/100ps
module bws_downstream_model
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // command
  input  wire logic       go,
  input  wire logic [2:0] sel,
  input  wire logic [3:0] len,
  // event lines
  output logic            downstream_parity_error_n,
  output logic            downstream_system_error_n,
  output logic            targetAbortSignaled,
  output logic            targetAbortReceived,
  output logic            masterAbortReceived,
  output logic            parityErrorDetected
);
  logic       goDly_r;
  logic [3:0] cnt_r;
  logic [2:0] sel_r;
  logic       act;

  always_ff @(posedge clk)
  begin
    goDly_r <= go;
    if (reset)
      cnt_r <= 4'h0;
    else if (go && !goDly_r)
    begin
      cnt_r <= len;
      sel_r <= sel;
    end
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end

  assign act = (cnt_r != 4'h0);
  assign downstream_parity_error_n = !(act && sel_r == 3'h0);
  assign downstream_system_error_n = !(act && sel_r == 3'h1);
  assign targetAbortSignaled       = act && sel_r == 3'h2;
  assign targetAbortReceived       = act && sel_r == 3'h3;
  assign masterAbortReceived       = act && sel_r == 3'h4;
  assign parityErrorDetected       = act && sel_r == 3'h5;
endmodule

// *** sim/bridge_window_and_secondary_status_tb.sv ***
/*
  Self-checking bench for the window and downstream status bank.
  Assumes the one-wait-state Avalon slave and registered forward outputs.
*/
`timescale 1ns/100ps
module bridge_window_and_secondary_status_tb;
  import bws_pkg::*;
  typedef struct {string n; logic [31:0] e; logic [31:0] m; logic f;}
    bws_note_t;

  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  avsAddress = 8'h00;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [3:0]  avsByteenable = 4'hf;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic        parN, sysN, taSig, taRcv, maRcv, perDet;
  logic [31:0] ioAddr = 32'h0;
  logic [31:0] memAddr = 32'h0;
  logic        ioFwd, memFwd;
  logic        evGo = 1'b0;
  logic [2:0]  evSel = 3'h0;
  logic [3:0]  evLen = 4'h1;
  logic        probe = 1'b0;
  logic        probeDly = 1'b0;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          seed = 42159;
  int          evBit [6] = '{24, 30, 27, 28, 29, 31};
  bws_note_t   notes [$];
  bws_note_t   note;

  bws_cfg_regs i_dut (.clk(clk), .reset(reset), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .downstream_parity_error_n(parN),
    .downstream_system_error_n(sysN), .targetAbortSignaled(taSig),
    .targetAbortReceived(taRcv), .masterAbortReceived(maRcv),
    .parityErrorDetected(perDet), .ioReqAddr(ioAddr), .memReqAddr(memAddr),
    .ioForward(ioFwd), .memForward(memFwd));

  bws_downstream_model i_agent (.clk(clk), .reset(reset), .go(evGo),
    .sel(evSel), .len(evLen), .downstream_parity_error_n(parN),
    .downstream_system_error_n(sysN), .targetAbortSignaled(taSig),
    .targetAbortReceived(taRcv), .masterAbortReceived(maRcv),
    .parityErrorDetected(perDet));

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // one transfer; an idle cycle follows so strobes never re-rise in a step
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] be);
    avsAddress <= a;
    avsWritedata <= d;
    avsByteenable <= be;
    avsWrite <= w;
    avsRead <= !w;
    do @(posedge clk); while (avsWaitrequest !== 1'b0);
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] be = 4'hf);
    bus(1'b1, a, d, be);
  endtask

  task automatic rd(string n, logic [7:0] a, logic [31:0] e,
                    logic [31:0] m = 32'hffffffff);
    notes.push_back('{n, e, m, 1'b0});
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  task automatic fwd(logic [31:0] io, logic [31:0] mem, logic [1:0] e);
    ioAddr <= io;
    memAddr <= mem;
    probe <= 1'b1;
    notes.push_back('{"forward", {30'h0, e}, 32'h3, 1'b1});
    @(posedge clk);
    probe <= 1'b0;
    @(posedge clk);
  endtask

  task automatic ev(int s, int len);
    evSel <= s[2:0];
    evLen <= len[3:0];
    evGo <= 1'b1;
    @(posedge clk);
    evGo <= 1'b0;
    repeat (len + 2) @(posedge clk);
  endtask

  function automatic logic inw(logic [31:0] a, logic [31:0] lo,
                               logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // program both windows and probe their edges plus random addresses
  task automatic win(logic [3:0] ib, logic [3:0] il, logic [15:0] us,
                     logic [15:0] ue, logic [11:0] mb, logic [11:0] ml);
    logic [31:0] a [4];
    logic [31:0] b [4];
    logic [31:0] iLo, iHi, mLo, mHi, r;
    iLo = {us, ib, 12'h000};
    iHi = {ue, il, 12'hfff};
    mLo = {mb, 20'h00000};
    mHi = {ml, 20'hfffff};
    wr(OFS_IOST, {16'h0, il, 4'h0, ib, 4'h0}, 4'h3);
    wr(OFS_IOUP, {ue, us});
    wr(OFS_MEM, {ml, 4'h0, mb, 4'h0});
    a = '{iLo, iLo - 1, iHi, iHi + 1};
    b = '{mLo, mLo - 1, mHi, mHi + 1};
    for (int i = 0; i < 4; i++)
      fwd(a[i], b[i], {inw(b[i], mLo, mHi),
                       inw(a[i], iLo, iHi)});
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      a[0] = {us, r[15:0]};
      fwd(a[0], r, {inw(r, mLo, mHi), inw(a[0], iLo, iHi)});
    end
  endtask

  task automatic reset_reads;
    rd("status", OFS_IOST, 32'h0220_0101);
    rd("membase", OFS_MEM, 32'h0);
    rd("ioupper", OFS_IOUP, 32'h0);
    rd("command", OFS_CMD, 32'h0);
  endtask

  always @(posedge clk)
  begin
    probeDly <= probe;
    if ((avsRead === 1'b1 && avsWaitrequest === 1'b0) || probeDly)
    begin
      if (notes.size() == 0)
        check("note queue", 32'h0, 32'h1);
      else
      begin
        note = notes.pop_front();
        check(note.n,
              (note.f ? {30'h0, memFwd, ioFwd} : avsReaddata) & note.m,
              note.e);
      end
    end
  end

  initial
  begin
    #200000;
    error_cnt++;
    complete_run();
  end

  initial
  begin
    logic [31:0] r;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    reset_reads();
    wr(OFS_IOST, 32'hffff_ffff);
    rd("status ro", OFS_IOST, 32'h0220_f1f1);
    wr(OFS_MEM, 32'hffff_ffff);
    rd("mem ro", OFS_MEM, 32'hfff0_fff0);
    r = $random(seed);
    wr(OFS_IOUP, r);
    rd("ioupper rw", OFS_IOUP, r);
    wr(8'h40, 32'hffff_ffff);
    rd("unmapped", 8'h40, 32'h0);
    wr(OFS_IOST, 32'h0000_0050, 4'h1);
    wr(OFS_IOST, 32'h0000_a000, 4'h2);
    rd("io nibbles", OFS_IOST, 32'h0220_a151);
    ev(0, 3);
    rd("parity off", OFS_IOST, 32'h0, 32'h0100_0000);
    wr(OFS_CMD, 32'h1 << CMD_PERR_EN_BIT);
    rd("command", OFS_CMD, 32'h0000_0040);
    for (int i = 0; i < 6; i++)
    begin
      ev(i, (i < 2) ? 3 : 1);
      rd("event", OFS_IOST, 32'h1 << evBit[i],
         32'h1 << evBit[i]);
    end
    wr(OFS_IOST, 32'h0100_0000, 4'hc);
    rd("w1c one", OFS_IOST, 32'hfa20_0000, 32'hffff_0000);
    evSel <= 3'h5;
    evLen <= 4'h1;
    evGo <= 1'b1;
    wr(OFS_IOST, 32'hf800_0000, 4'hc);
    evGo <= 1'b0;
    rd("set wins", OFS_IOST, 32'h8220_0000, 32'hffff_0000);
    wr(OFS_IOST, 32'h8000_0000, 4'hc);
    rd("cleared", OFS_IOST, 32'h0220_0000, 32'hffff_0000);
    win(4'h2, 4'h5, 16'h1234, 16'h1234, 12'h123, 12'h456);
    win(4'h5, 4'h2, 16'h1234, 16'h1234, 12'h456, 12'h123);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    reset_reads();
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule
